//--- logic/srmc_pkg.sv
// Purpose: Shared constants for the secured region host sequencer.
// Assumes: Word- or byte-mode flash bus, 16-bit data, clock of 40 MHz.
// Notes: Pin timings are plain defaults; adjust to the part in use.
package srmc_pkg;
    localparam logic [15:0] SRMC_UNLOCK1_ADDR = 16'h0555;
    localparam logic [15:0] SRMC_UNLOCK2_ADDR = 16'h02AA;
    localparam logic [15:0] SRMC_EXIT4_ADDR = 16'h0000;
    localparam logic [15:0] SRMC_UNLOCK1_BYTE_ADDR = 16'h0AAA;
    localparam logic [15:0] SRMC_UNLOCK2_BYTE_ADDR = 16'h0555;
    localparam logic [15:0] SRMC_UNLOCK1_DATA = 16'h00AA;
    localparam logic [15:0] SRMC_UNLOCK2_DATA = 16'h0055;
    localparam logic [15:0] SRMC_ENTRY_DATA = 16'h0088;
    localparam logic [15:0] SRMC_PROG_DATA = 16'h00A0;
    localparam logic [15:0] SRMC_EXIT3_DATA = 16'h0090;
    localparam logic [15:0] SRMC_EXIT4_DATA = 16'h0000;
    localparam int SRMC_REGION_WORDS = 128;
    localparam int SRMC_LOCK_BIT = 7;
    localparam int SRMC_CLK_MHZ = 40;
    localparam int SRMC_PULSE_NS = 50;
    localparam int SRMC_PULSE_CYC = (SRMC_PULSE_NS * SRMC_CLK_MHZ + 999) / 1000;
    localparam int SRMC_READ_NS = 100;
    localparam int SRMC_READ_CYC = (SRMC_READ_NS * SRMC_CLK_MHZ + 999) / 1000;
    localparam int SRMC_RESET_NS = 500;
    localparam int SRMC_RESET_CYC = (SRMC_RESET_NS * SRMC_CLK_MHZ + 999) / 1000;
    typedef enum logic [2:0]
    {
        SRMC_CMD_ENTER = 3'h0,
        SRMC_CMD_EXIT = 3'h1,
        SRMC_CMD_PROG = 3'h2,
        SRMC_CMD_READ = 3'h3,
        SRMC_CMD_RESET = 3'h4
    } srmc_cmd_t;
    typedef enum logic [2:0]
    {
        SRMC_IDLE = 3'b000,
        SRMC_SETUP = 3'b001,
        SRMC_PULSE = 3'b011,
        SRMC_HOLD = 3'b010,
        SRMC_RDWAIT = 3'b110,
        SRMC_RST = 3'b111
    } srmc_state_t;
endpackage

//--- logic/srmc_seq_rom.sv
// Purpose: Command cycle table for entry, exit and program sequences.
// Assumes: Index counts bus cycles within one sequence.
// Notes: Output is registered so the caller sees it one cycle later.
`timescale 1ns/1ps
`default_nettype none
module srmc_seq_rom
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] cmd,
    input wire logic [1:0] idx,
    input wire logic byte_mode,
    output logic [15:0] addr,
    output logic [15:0] data
);
    wire logic [15:0] a1 = byte_mode ? srmc_pkg::SRMC_UNLOCK1_BYTE_ADDR
                                     : srmc_pkg::SRMC_UNLOCK1_ADDR;
    wire logic [15:0] a2 = byte_mode ? srmc_pkg::SRMC_UNLOCK2_BYTE_ADDR
                                     : srmc_pkg::SRMC_UNLOCK2_ADDR;
    wire logic [15:0] third = (cmd == 3'h0) ? srmc_pkg::SRMC_ENTRY_DATA
                            : (cmd == 3'h1) ? srmc_pkg::SRMC_EXIT3_DATA
                            : srmc_pkg::SRMC_PROG_DATA;
    wire logic [15:0] a_sel = (idx == 2'h0) ? a1 : (idx == 2'h1) ? a2
                            : (idx == 2'h2) ? a1 : srmc_pkg::SRMC_EXIT4_ADDR;
    wire logic [15:0] d_sel = (idx == 2'h0) ? srmc_pkg::SRMC_UNLOCK1_DATA
                            : (idx == 2'h1) ? srmc_pkg::SRMC_UNLOCK2_DATA
                            : (idx == 2'h2) ? third : srmc_pkg::SRMC_EXIT4_DATA;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            addr <= 16'h0000;
            data <= 16'h0000;
        end
        else
        begin
            addr <= a_sel;
            data <= d_sel;
        end
    end
endmodule
`default_nettype wire

//--- logic/srmc_host.sv
// Purpose: Host sequencer driving secured region commands onto a NOR flash.
// Assumes: Flash pins are sampled synchronously to clk.
// Notes: One request at a time; busy stays high until the bus is idle.
`timescale 1ns/1ps
`default_nettype none
module srmc_host
#(
    parameter int ADDR_W = 16
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic [2:0] req_cmd,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [15:0] req_data,
    input wire logic byte_mode,
    input wire logic region_locked,
    input wire logic flash_busy,
    output logic req_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic rsp_refused,
    output logic in_region_mode,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [15:0] flash_dq_out,
    input wire logic [15:0] flash_dq_in,
    output logic flash_dq_oe_n,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n,
    output logic flash_reset_n,
    output logic flash_accel_n
);
    srmc_pkg::srmc_state_t state_reg, state_next;
    logic [2:0] cmd_reg;
    logic [1:0] idx_reg;
    logic [7:0] cnt_reg;
    logic [ADDR_W-1:0] uaddr_reg;
    logic [15:0] udata_reg;
    logic [15:0] rom_addr, rom_data;
    logic [15:0] addr_hold;
    wire logic start = req_valid && req_ready;
    // Programs in region mode after lock, or any command but a reset while the flash is busy, are refused.
    wire logic refuse = (req_cmd == srmc_pkg::SRMC_CMD_PROG && in_region_mode && region_locked)
                     || (flash_busy && req_cmd != srmc_pkg::SRMC_CMD_RESET);
    wire logic [1:0] last_idx = (cmd_reg == srmc_pkg::SRMC_CMD_ENTER) ? 2'h2 : 2'h3;
    wire logic user_cycle = (cmd_reg == srmc_pkg::SRMC_CMD_PROG) && (idx_reg == 2'h3);
    wire logic cnt_done = (cnt_reg == 8'h00);
    wire logic [7:0] pulse_len = 8'(srmc_pkg::SRMC_PULSE_CYC);
    wire logic [7:0] read_len = 8'(srmc_pkg::SRMC_READ_CYC);
    wire logic [7:0] rst_len = 8'(srmc_pkg::SRMC_RESET_CYC);
    // The table is registered, so it is fed the command and step that the coming setup
    // cycle will use rather than the ones now in flight.
    wire logic [2:0] rom_cmd = (state_reg == srmc_pkg::SRMC_IDLE) ? req_cmd : cmd_reg;
    wire logic [1:0] idx_step = idx_reg + 2'h1;
    wire logic [1:0] rom_idx = (state_reg == srmc_pkg::SRMC_IDLE) ? 2'h0
                             : (state_reg == srmc_pkg::SRMC_HOLD) ? idx_step : idx_reg;
    srmc_seq_rom u_rom
    (
        .clk(clk),
        .rst_n(rst_n),
        .cmd(rom_cmd),
        .idx(rom_idx),
        .byte_mode(byte_mode),
        .addr(rom_addr),
        .data(rom_data)
    );
    assign addr_hold = rom_addr;
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            srmc_pkg::SRMC_IDLE:
                if (start && !refuse)
                begin
                    if (req_cmd == srmc_pkg::SRMC_CMD_READ)
                        state_next = srmc_pkg::SRMC_RDWAIT;
                    else if (req_cmd == srmc_pkg::SRMC_CMD_RESET)
                        state_next = srmc_pkg::SRMC_RST;
                    else
                        state_next = srmc_pkg::SRMC_SETUP;
                end
            srmc_pkg::SRMC_SETUP: state_next = srmc_pkg::SRMC_PULSE;
            srmc_pkg::SRMC_PULSE: if (cnt_done) state_next = srmc_pkg::SRMC_HOLD;
            srmc_pkg::SRMC_HOLD:
                state_next = (idx_reg == last_idx) ? srmc_pkg::SRMC_IDLE
                                                   : srmc_pkg::SRMC_SETUP;
            srmc_pkg::SRMC_RDWAIT: if (cnt_done) state_next = srmc_pkg::SRMC_IDLE;
            srmc_pkg::SRMC_RST: if (cnt_done) state_next = srmc_pkg::SRMC_IDLE;
            default: state_next = srmc_pkg::SRMC_IDLE;
        endcase
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= srmc_pkg::SRMC_IDLE;
            cmd_reg <= 3'h0;
            idx_reg <= 2'h0;
            cnt_reg <= 8'h00;
            uaddr_reg <= '0;
            udata_reg <= 16'h0000;
        end
        else
        begin
            state_reg <= state_next;
            if (start && state_reg == srmc_pkg::SRMC_IDLE)
            begin
                cmd_reg <= req_cmd;
                uaddr_reg <= req_addr;
                udata_reg <= req_data;
                idx_reg <= 2'h0;
                cnt_reg <= (req_cmd == srmc_pkg::SRMC_CMD_RESET) ? rst_len : read_len;
            end
            else if (state_reg == srmc_pkg::SRMC_SETUP)
                cnt_reg <= pulse_len;
            else if (!cnt_done)
                cnt_reg <= cnt_reg - 8'h01;
            if (state_reg == srmc_pkg::SRMC_HOLD)
                idx_reg <= idx_reg + 2'h1;
        end
    end
    // Flash pins, all registered.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            flash_addr <= '0;
            flash_dq_out <= 16'h0000;
            flash_dq_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_reset_n <= 1'b1;
            flash_accel_n <= 1'b1;
        end
        else
        begin
            // Accelerated programming is never used by this sequencer.
            flash_accel_n <= 1'b1;
            flash_reset_n <= (state_next != srmc_pkg::SRMC_RST);
            // Select and data stay put one cycle past the rising write strobe, so the
            // write is latched with hold time to spare.
            flash_ce_n <= !(state_next == srmc_pkg::SRMC_PULSE
                            || state_next == srmc_pkg::SRMC_HOLD
                            || state_next == srmc_pkg::SRMC_RDWAIT);
            flash_we_n <= (state_next != srmc_pkg::SRMC_PULSE);
            flash_oe_n <= (state_next != srmc_pkg::SRMC_RDWAIT);
            flash_dq_oe_n <= !(state_next == srmc_pkg::SRMC_PULSE
                               || state_next == srmc_pkg::SRMC_HOLD);
            if (state_reg == srmc_pkg::SRMC_SETUP)
            begin
                flash_addr <= user_cycle ? uaddr_reg : ADDR_W'(addr_hold);
                flash_dq_out <= user_cycle ? udata_reg : rom_data;
            end
            else if (start && req_cmd == srmc_pkg::SRMC_CMD_READ)
                flash_addr <= req_addr;
        end
    end
    // Handshake and mode tracking.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_refused <= 1'b0;
            rsp_data <= 16'h0000;
            in_region_mode <= 1'b0;
        end
        else
        begin
            req_ready <= (state_next == srmc_pkg::SRMC_IDLE) && !start;
            rsp_valid <= 1'b0;
            rsp_refused <= 1'b0;
            if (start && refuse)
            begin
                rsp_valid <= 1'b1;
                rsp_refused <= 1'b1;
            end
            if (state_reg == srmc_pkg::SRMC_RDWAIT && cnt_done)
            begin
                rsp_valid <= 1'b1;
                rsp_data <= flash_dq_in;
            end
            if (state_reg == srmc_pkg::SRMC_HOLD && idx_reg == last_idx)
            begin
                rsp_valid <= 1'b1;
                if (cmd_reg == srmc_pkg::SRMC_CMD_ENTER)
                    in_region_mode <= 1'b1;
                else if (cmd_reg == srmc_pkg::SRMC_CMD_EXIT)
                    in_region_mode <= 1'b0;
            end
            if (state_reg == srmc_pkg::SRMC_RST && cnt_done)
            begin
                rsp_valid <= 1'b1;
                in_region_mode <= 1'b0;
            end
        end
    end
    property p_exit_clears;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == srmc_pkg::SRMC_HOLD && cmd_reg == srmc_pkg::SRMC_CMD_EXIT
         && idx_reg == 2'h3) |=> !in_region_mode;
    endproperty
    AST_EXIT_CLEARS: assert property (p_exit_clears) else $error("exit left mode set");
    AST_ENTRY_SETS: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == srmc_pkg::SRMC_HOLD && cmd_reg == srmc_pkg::SRMC_CMD_ENTER
         && idx_reg == 2'h2) |=> in_region_mode) else $error("entry did not set mode");
    AST_ACCEL_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        in_region_mode |-> flash_accel_n) else $error("accel used in mode");
    AST_RESET_MODE: assert property (@(posedge clk) disable iff (!rst_n)
        !flash_reset_n ##1 flash_reset_n |-> !in_region_mode) else $error("reset kept mode");
    AST_LOCK_REFUSE: assert property (@(posedge clk) disable iff (!rst_n)
        (start && req_cmd == srmc_pkg::SRMC_CMD_PROG && in_region_mode && region_locked)
        |=> rsp_refused && state_reg == srmc_pkg::SRMC_IDLE) else $error("locked prog ran");
    AST_BUSY_REFUSE: assert property (@(posedge clk) disable iff (!rst_n)
        (start && flash_busy && req_cmd == srmc_pkg::SRMC_CMD_READ) |=> rsp_refused)
        else $error("access while busy");
    sequence s_third_write;
        state_reg == srmc_pkg::SRMC_SETUP && idx_reg == 2'h2
        && cmd_reg == srmc_pkg::SRMC_CMD_PROG;
    endsequence
    AST_PROG_SETUP: assert property (@(posedge clk) disable iff (!rst_n)
        s_third_write |=> flash_dq_out == srmc_pkg::SRMC_PROG_DATA) else $error("bad A0");
    AST_MODE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(in_region_mode) |-> ($past(cmd_reg) == srmc_pkg::SRMC_CMD_EXIT
                                  || $past(cmd_reg) == srmc_pkg::SRMC_CMD_RESET))
        else $error("mode dropped oddly");
endmodule
`default_nettype wire

//--- testbench/srmc_flash_model.sv
// Purpose: Behavioural flash device on the far side of the host sequencer.
// Assumes: A write lands on the rising edge of we_n while ce_n is low.
// Notes: Released data lines show the inverse of the last word read.
`timescale 1ns/1ps
`default_nettype none
module srmc_flash_model
#(
    parameter logic [15:0] SECTOR_WORDS = 16'h4000
)
(
    input wire logic clk,
    input wire logic [15:0] addr,
    input wire logic [15:0] dq,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic reset_n,
    input wire logic byte_mode,
    input wire logic locked,
    output logic [15:0] dq_out
);
    logic mode_reg = 1'b0;
    logic [2:0] step_reg = 3'h0;
    logic [15:0] last_reg = 16'h0000;
    logic [15:0] rd_word;
    logic [15:0] region [0:127];
    wire logic [15:0] a1 = byte_mode ? 16'h0AAA : 16'h0555;
    wire logic [15:0] a2 = byte_mode ? 16'h0555 : 16'h02AA;
    // A fresh customer region is erased flash, free for ordinary use.
    initial
    begin
        for (int i = 0; i < 128; i++)
            region[i] = 16'hFFFF;
    end
    always @(posedge we_n or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_reg <= 1'b0;
            step_reg <= 3'h0;
        end
        else if (!ce_n)
        begin
            step_reg <= 3'h0;
            case (step_reg)
                3'h0: if (addr == a1 && dq == 16'h00AA) step_reg <= 3'h1;
                3'h1: if (addr == a2 && dq == 16'h0055) step_reg <= 3'h2;
                3'h2:
                begin
                    if (addr == a1 && dq == 16'h0088) mode_reg <= 1'b1;
                    if (addr == a1 && dq == 16'h00A0) step_reg <= 3'h3;
                    if (addr == a1 && dq == 16'h0090 && mode_reg) step_reg <= 3'h4;
                end
                // Flash bits only clear; a locked region is not written and stays as it was.
                3'h3: if (mode_reg && !locked && addr < 16'h0080)
                    region[addr[6:0]] <= region[addr[6:0]] & dq;
                default: if (addr == 16'h0000 && dq == 16'h0000) mode_reg <= 1'b0;
            endcase
        end
    end
    always_comb
    begin
        if (!mode_reg || addr >= SECTOR_WORDS)
            rd_word = addr ^ 16'hA5A5;
        else if (addr < 16'h0080)
            rd_word = region[addr[6:0]];
        else
            rd_word = ~last_reg;
    end
    always @(posedge clk)
    begin
        if (!ce_n && !oe_n)
            last_reg <= rd_word;
    end
    assign dq_out = (!ce_n && !oe_n && reset_n) ? rd_word : ~last_reg;
endmodule
`default_nettype wire

//--- testbench/srmc_host_tb.sv
// Purpose: Self-checking bench for the secured region host sequencer.
// Assumes: Flash model answers reads at once; one request at a time.
// Notes: Mode is judged both at the host port and inside the flash model.
`timescale 1ns/1ps
`default_nettype none
module srmc_host_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic [2:0] req_cmd = 3'h0;
    logic [15:0] req_addr = 16'h0000;
    logic [15:0] req_data = 16'h0000;
    logic byte_mode = 1'b0;
    logic region_locked = 1'b0;
    logic flash_busy = 1'b0;
    logic req_ready, rsp_valid, rsp_refused, in_region_mode, refused;
    logic [15:0] rsp_data, flash_addr, flash_dq_out, flash_dq_in, got;
    logic flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n, flash_accel_n;
    int err_total = 0;
    int n_compared = 0;
    always #12.5 clk = ~clk;
    srmc_host #(.ADDR_W(16)) i_srmc_host (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data), .byte_mode(byte_mode),
        .region_locked(region_locked), .flash_busy(flash_busy), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_refused(rsp_refused),
        .in_region_mode(in_region_mode), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
        .flash_dq_in(flash_dq_in), .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
        .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_reset_n(flash_reset_n),
        .flash_accel_n(flash_accel_n));
    srmc_flash_model i_srmc_flash_model (.clk(clk), .addr(flash_addr), .dq(flash_dq_out),
        .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n), .reset_n(flash_reset_n),
        .byte_mode(byte_mode), .locked(region_locked), .dq_out(flash_dq_in));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_compared++;
        if (exp !== seen)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic do_req(input logic [2:0] cmd, input logic [15:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req_cmd <= cmd;
        req_addr <= a;
        req_data <= d;
        req_valid <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (req_ready !== 1'b1 && n < 300);
        req_valid <= 1'b0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rsp_valid !== 1'b1 && n < 600);
        got = rsp_data;
        refused = rsp_refused;
        chk("handshake", 16'h0001, {15'h0000, n < 600});
        // Let registered mode flags settle before anyone looks at them.
        repeat (2) @(negedge clk);
        chk("pins idle", 16'h001F, {11'h000, flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n,
            flash_reset_n});
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        do_req(3'h3, a, 16'h0000);
        chk("read data", exp, got);
    endtask
    task automatic chk_mode(input logic exp);
        chk("host mode", {15'h0000, exp}, {15'h0000, in_region_mode});
        chk("flash mode", {15'h0000, exp}, {15'h0000, i_srmc_flash_model.mode_reg});
    endtask
    task automatic t_enter();
        rd(16'h0010, 16'h0010 ^ 16'hA5A5);
        do_req(3'h0, 16'h0000, 16'h0000);
        chk_mode(1'b1);
        chk("accel", 16'h0001, {15'h0000, flash_accel_n});
        rd(16'h0005, 16'hFFFF);
        rd(16'h5000, 16'h5000 ^ 16'hA5A5);
    endtask
    task automatic t_program();
        do_req(3'h2, 16'h0003, 16'h1234);
        chk("refused", 16'h0000, {15'h0000, refused});
        rd(16'h0003, 16'h1234);
        rd(16'h0003, 16'h1234);
        chk_mode(1'b1);
    endtask
    task automatic t_locked();
        @(posedge clk);
        region_locked <= 1'b1;
        do_req(3'h2, 16'h0004, 16'h0000);
        chk("refused", 16'h0001, {15'h0000, refused});
        rd(16'h0004, 16'hFFFF);
        @(posedge clk);
        flash_busy <= 1'b1;
        do_req(3'h3, 16'h0003, 16'h0000);
        chk("refused", 16'h0001, {15'h0000, refused});
        @(posedge clk);
        flash_busy <= 1'b0;
        region_locked <= 1'b0;
    endtask
    task automatic t_exit();
        do_req(3'h1, 16'h0000, 16'h0000);
        chk_mode(1'b0);
        rd(16'h0003, 16'h0003 ^ 16'hA5A5);
    endtask
    task automatic t_byte_reset();
        @(posedge clk);
        byte_mode <= 1'b1;
        do_req(3'h0, 16'h0000, 16'h0000);
        chk_mode(1'b1);
        do_req(3'h4, 16'h0000, 16'h0000);
        chk_mode(1'b0);
        @(posedge clk);
        byte_mode <= 1'b0;
    endtask
    task automatic print_verdict();
        if (err_total == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_enter();
        t_program();
        t_locked();
        t_exit();
        t_byte_reset();
        print_verdict();
    end
    // The tests need well under 1000 cycles; this leaves ample margin.
    initial
    begin
        #250000;
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire
